// *** rtl/adcs_regs.vh ***
`ifndef ADCS_REGS_VH
`define ADCS_REGS_VH

// converter shape
`define ADCS_NUM_CH        17
`define ADCS_CH_W          5
`define ADCS_CODE_W        12
`define ADCS_NUM_WIN       6

// limit block-access commands and their byte counts
`define ADCS_CMD_ALL_LIM   8'h40
`define ADCS_CMD_LOW_LIM   8'h46
`define ADCS_LEN_ALL_LIM   24
`define ADCS_LEN_LOW_LIM   12
`define ADCS_LAST_BYTE     5'h17
`define ADCS_NUM_LIM       12

// limit reset values
`define ADCS_UPPER_RST     12'hfff
`define ADCS_LOWER_RST     12'h000

// internal oscillator timing
`define ADCS_CLK_NS        20
`define ADCS_T_TRACK_NS    2000
`define ADCS_T_BIT_NS      200
// sized to the 16-bit timer parameters: 2000 ns and 200 ns of 20 ns clock
`define ADCS_TRACK_CYC     16'h0064
`define ADCS_BIT_CYC       16'h000a

// sequencer states
`define ADCS_S_IDLE        2'h0
`define ADCS_S_SCAN        2'h1
`define ADCS_S_CONV        2'h2

// converter states
`define ADCS_C_IDLE        2'h0
`define ADCS_C_TRACK       2'h1
`define ADCS_C_HOLD        2'h2

`endif

// *** rtl/adcs_sar.v ***
`timescale 1ns/1ns
`include "adcs_regs.vh"
module adcs_sar #(
   parameter [15:0] TRACK_CYC = `ADCS_TRACK_CYC,
   parameter [15:0] BIT_CYC   = `ADCS_BIT_CYC
) (
   // clock and reset
   input  wire                    mclk,
   input  wire                    reset_n,
   // request
   input  wire                    start,
   input  wire [`ADCS_CH_W-1:0]   start_ch,
   // analog front end
   input  wire                    comp_hi,
   output reg  [`ADCS_CH_W-1:0]   mux_sel_q,
   output reg                     mux_closed_q,
   output reg  [`ADCS_CODE_W-1:0] trial_q,
   // answer
   output reg                     done_q,
   output reg  [`ADCS_CODE_W-1:0] result_q
);

   reg  [1:0]              state_q;
   reg  [15:0]             cnt_q;
   reg  [`ADCS_CODE_W-1:0] code_q;
   reg  [`ADCS_CODE_W-1:0] mask_q;
   reg                     comp_s1_q;
   reg                     comp_s2_q;
   wire [`ADCS_CODE_W-1:0] code_d;

   // comparator high means input at or above the trial level
   assign code_d = comp_s2_q ? trial_q : code_q;

   always @(posedge mclk) begin
      if (!reset_n) begin
         comp_s1_q    <= 1'b0;
         comp_s2_q    <= 1'b0;
         state_q      <= `ADCS_C_IDLE;
         cnt_q        <= 16'h0000;
         code_q       <= 12'h000;
         mask_q       <= 12'h000;
         trial_q      <= 12'h000;
         mux_sel_q    <= 5'h00;
         mux_closed_q <= 1'b0;
         done_q       <= 1'b0;
         result_q     <= 12'h000;
      end else begin
         comp_s1_q <= comp_hi;
         comp_s2_q <= comp_s1_q;
         done_q    <= 1'b0;
         case (state_q)
            `ADCS_C_IDLE: begin
               if (start) begin
                  mux_sel_q    <= start_ch;
                  mux_closed_q <= 1'b1;
                  cnt_q        <= 16'h0000;
                  state_q      <= `ADCS_C_TRACK;
               end
            end
            // R05: track time from oscillator
            `ADCS_C_TRACK: begin
               if (cnt_q == TRACK_CYC - 16'h0001) begin
                  // R07: all switches open in hold
                  mux_closed_q <= 1'b0;
                  cnt_q        <= 16'h0000;
                  code_q       <= 12'h000;
                  mask_q       <= 12'h800;
                  trial_q      <= 12'h800;
                  state_q      <= `ADCS_C_HOLD;
               end else begin
                  cnt_q <= cnt_q + 16'h0001;
               end
            end
            // R08: binary search gives floor code
            `ADCS_C_HOLD: begin
               // bit time covers the two-stage comparator sync
               if (cnt_q == BIT_CYC - 16'h0001) begin
                  cnt_q  <= 16'h0000;
                  code_q <= code_d;
                  mask_q <= mask_q >> 1;
                  if (mask_q[0]) begin
                     result_q <= code_d;
                     done_q   <= 1'b1;
                     state_q  <= `ADCS_C_IDLE;
                  end else begin
                     trial_q <= code_d | (mask_q >> 1);
                  end
               end else begin
                  cnt_q <= cnt_q + 16'h0001;
               end
            end
            default: begin
               state_q <= `ADCS_C_IDLE;
            end
         endcase
      end
   end

endmodule

// *** rtl/adcs_sequencer.v ***
// Function
// R01: command 0x40 moves 24 bytes covering all upper and lower limits.
// R02: command 0x46 moves 12 bytes covering only the lower limits.
// R03: multiplexer chooses among 16 external inputs plus temperature.
// R04: each result lands in its own channel's result register, readable.
// R05: track and hold durations are timed by the internal oscillator.
// R06: window compare on six channels drives external interrupt outputs.
// R07: in hold all switches open; code then stored per channel.
// R08: code is floor of 4096 times input over reference, 12 bits.
// R09: per-channel enable bits in three registers; enabling starts nothing.
// R10: idle until a run starts; only enabled channels are converted.
// R11: any single-shot trigger write starts a pass when continuous is 0; the code ignores a trigger while busy.
// R12: single-shot pass ends in idle without another pass.
// R13: continuous run uses the same per-channel sequence as single-shot.
// R14: continuous passes repeat until continuous-run is cleared.
// R15: reference comes from external pin or internal generator.
// R16: channels 1-3 and 9-11 compared against upper and lower limits.
// R17: two active-low interrupts: channels 1-3 and channels 9-11.
// R18: ascending channel order, disabled channels skipped with no time.
// R19: empty enable set finishes a pass at once; continuous keeps checking.
`timescale 1ns/1ns
`include "adcs_regs.vh"
module adcs_sequencer #(
   parameter [15:0] TRACK_CYC = `ADCS_TRACK_CYC,
   parameter [15:0] BIT_CYC   = `ADCS_BIT_CYC
) (
   // clock and reset
   input  wire                    mclk,
   input  wire                    reset_n,
   // channel enables
   input  wire [7:0]              channel_enable_reg_a,
   input  wire [7:0]              channel_enable_reg_b,
   input  wire                    channel_enable_reg_c,
   // run control
   input  wire                    single_shot_trigger,
   input  wire                    continuous_run,
   input  wire                    ref_select_internal,
   // status
   output reg                     busy_q,
   output reg                     seq_done_q,
   output reg                     any_oob_q,
   output reg  [`ADCS_NUM_WIN-1:0] oob_flags_q,
   // analog front end
   input  wire                    comp_hi,
   output wire [`ADCS_CH_W-1:0]   mux_sel_q,
   output wire                    mux_closed_q,
   output wire [`ADCS_CODE_W-1:0] trial_q,
   output reg                     ref_internal_en_q,
   // result read
   input  wire [`ADCS_CH_W-1:0]   result_sel,
   output reg  [`ADCS_CODE_W-1:0] channel_result_reg_q,
   // limit block access
   input  wire                    blk_start,
   input  wire [7:0]              blk_cmd,
   input  wire                    blk_byte_valid,
   input  wire                    blk_write,
   input  wire [7:0]              blk_wr_byte,
   output reg  [7:0]              blk_rd_byte_q,
   output reg                     blk_active_q,
   output reg                     blk_error_q,
   // interrupt pins, open drain
   output reg                     irq_low_group_o_q,
   output reg                     irq_low_group_oe_n_q,
   output reg                     irq_high_group_o_q,
   output reg                     irq_high_group_oe_n_q
);

   reg  [1:0]              state_q;
   reg  [`ADCS_CH_W-1:0]   ptr_q;
   reg  [`ADCS_CH_W-1:0]   ch_q;
   reg                     sar_start_q;
   reg  [`ADCS_CODE_W-1:0] res_q [0:`ADCS_NUM_CH-1];
   reg  [`ADCS_CODE_W-1:0] lim_q [0:`ADCS_NUM_LIM-1];
   reg  [4:0]              bp_q;
   reg  [`ADCS_CH_W-1:0]   nxt;
   reg                     found;
   reg  [3:0]              lim_idx;
   reg                     lim_hi;
   reg  [7:0]              lim_byte;
   wire [`ADCS_NUM_CH-1:0] en_all;
   wire                    sar_done;
   wire [`ADCS_CODE_W-1:0] sar_result;
   wire [`ADCS_NUM_WIN-1:0] oob;
   wire [`ADCS_NUM_WIN*`ADCS_CODE_W-1:0] upper_flat;
   wire [`ADCS_NUM_WIN*`ADCS_CODE_W-1:0] lower_flat;
   integer i;
   integer j;
   integer k;

   // R09: enable bits from three registers
   assign en_all = {channel_enable_reg_c, channel_enable_reg_b,
                    channel_enable_reg_a};

   // R18: lowest enabled channel at or above pointer
   always @* begin
      nxt   = 5'h00;
      found = 1'b0;
      for (j = `ADCS_NUM_CH - 1; j >= 0; j = j - 1) begin
         if (en_all[j] && (j[4:0] >= ptr_q)) begin
            nxt   = j[4:0];
            found = 1'b1;
         end
      end
   end

   // sequencer
   always @(posedge mclk) begin
      if (!reset_n) begin
         state_q     <= `ADCS_S_IDLE;
         ptr_q       <= 5'h00;
         ch_q        <= 5'h00;
         sar_start_q <= 1'b0;
         seq_done_q  <= 1'b0;
         busy_q      <= 1'b0;
      end else begin
         sar_start_q <= 1'b0;
         seq_done_q  <= 1'b0;
         case (state_q)
            // R10: idle until a run is requested
            `ADCS_S_IDLE: begin
               busy_q <= 1'b0;
               // R11: trigger or continuous_run starts a pass from idle
               if (continuous_run || single_shot_trigger) begin
                  ptr_q   <= 5'h00;
                  busy_q  <= 1'b1;
                  state_q <= `ADCS_S_SCAN;
               end
            end
            `ADCS_S_SCAN: begin
               if (found) begin
                  // R03: any of the 17 mux inputs
                  ch_q        <= nxt;
                  sar_start_q <= 1'b1;
                  state_q     <= `ADCS_S_CONV;
               end else begin
                  // R19: empty set ends the pass at once
                  seq_done_q <= 1'b1;
                  ptr_q      <= 5'h00;
                  // R14: continuous starts a new pass
                  if (continuous_run) begin
                     state_q <= `ADCS_S_SCAN;
                  end else begin
                     // R12: single-shot returns to idle
                     busy_q  <= 1'b0;
                     state_q <= `ADCS_S_IDLE;
                  end
               end
            end
            // R13: same per-channel steps in both modes
            `ADCS_S_CONV: begin
               if (sar_done) begin
                  ptr_q   <= ch_q + 5'h01;
                  state_q <= `ADCS_S_SCAN;
               end
            end
            default: begin
               state_q <= `ADCS_S_IDLE;
            end
         endcase
      end
   end

   adcs_sar #(
      .TRACK_CYC    (TRACK_CYC),
      .BIT_CYC      (BIT_CYC)
   ) u_sar (
      .mclk         (mclk),
      .reset_n      (reset_n),
      .start        (sar_start_q),
      .start_ch     (ch_q),
      .comp_hi      (comp_hi),
      .mux_sel_q    (mux_sel_q),
      .mux_closed_q (mux_closed_q),
      .trial_q      (trial_q),
      .done_q       (sar_done),
      .result_q     (sar_result)
   );

   // R04: results per channel, read port
   always @(posedge mclk) begin
      if (!reset_n) begin
         for (i = 0; i < `ADCS_NUM_CH; i = i + 1) begin
            res_q[i] <= 12'h000;
         end
         channel_result_reg_q <= 12'h000;
      end else begin
         // R07: code stored after hold
         if (sar_done) begin
            res_q[ch_q] <= sar_result;
         end
         if (result_sel < 5'h11) begin
            channel_result_reg_q <= res_q[result_sel];
         end else begin
            channel_result_reg_q <= 12'h000;
         end
      end
   end

   // R15: reference source select
   always @(posedge mclk) begin
      if (!reset_n) begin
         ref_internal_en_q <= 1'b0;
      end else begin
         ref_internal_en_q <= ref_select_internal;
      end
   end

   // limit image: entries 0-5 upper, 6-11 lower, each high byte first
   always @* begin
      lim_idx  = bp_q[4:1];
      lim_hi   = ~bp_q[0];
      lim_byte = lim_hi ? {4'h0, lim_q[lim_idx][11:8]}
                        : lim_q[lim_idx][7:0];
   end

   // limit block access
   always @(posedge mclk) begin
      if (!reset_n) begin
         for (k = 0; k < `ADCS_NUM_LIM; k = k + 1) begin
            if (k < `ADCS_NUM_WIN) begin
               lim_q[k] <= `ADCS_UPPER_RST;
            end else begin
               lim_q[k] <= `ADCS_LOWER_RST;
            end
         end
         bp_q          <= 5'h00;
         blk_active_q  <= 1'b0;
         blk_error_q   <= 1'b0;
         blk_rd_byte_q <= 8'h00;
      end else begin
         blk_error_q <= 1'b0;
         if (blk_start) begin
            // R01: all limits, 24 bytes
            if (blk_cmd == `ADCS_CMD_ALL_LIM) begin
               bp_q         <= 5'h00;
               blk_active_q <= 1'b1;
            // R02: lower limits, last 12 bytes
            end else if (blk_cmd == `ADCS_CMD_LOW_LIM) begin
               bp_q         <= 5'h0c;
               blk_active_q <= 1'b1;
            end else begin
               blk_active_q <= 1'b0;
               blk_error_q  <= 1'b1;
            end
         end else if (blk_active_q && blk_byte_valid) begin
            if (blk_write) begin
               if (lim_hi) begin
                  lim_q[lim_idx][11:8] <= blk_wr_byte[3:0];
               end else begin
                  lim_q[lim_idx][7:0] <= blk_wr_byte;
               end
            end else begin
               blk_rd_byte_q <= lim_byte;
            end
            // transfer ends after the last limit byte
            if (bp_q == `ADCS_LAST_BYTE) begin
               blk_active_q <= 1'b0;
            end else begin
               bp_q <= bp_q + 5'h01;
            end
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < `ADCS_NUM_WIN; g = g + 1) begin : lim
         assign upper_flat[g*12 +: 12] = lim_q[g];
         assign lower_flat[g*12 +: 12] = lim_q[g + `ADCS_NUM_WIN];
      end
   endgenerate

   // R06: window compare on six channels
   adcs_window u_win (
      .mclk       (mclk),
      .reset_n    (reset_n),
      .wr_valid   (sar_done),
      .wr_ch      (ch_q),
      .wr_code    (sar_result),
      .upper_flat (upper_flat),
      .lower_flat (lower_flat),
      .oob        (oob)
   );

   // R17: active-low group interrupts, pulled low only
   always @(posedge mclk) begin
      if (!reset_n) begin
         oob_flags_q           <= 6'h00;
         any_oob_q             <= 1'b0;
         irq_low_group_o_q     <= 1'b0;
         irq_low_group_oe_n_q  <= 1'b1;
         irq_high_group_o_q    <= 1'b0;
         irq_high_group_oe_n_q <= 1'b1;
      end else begin
         oob_flags_q           <= oob;
         any_oob_q             <= |oob;
         irq_low_group_o_q     <= 1'b0;
         irq_low_group_oe_n_q  <= ~(|oob[2:0]);
         irq_high_group_o_q    <= 1'b0;
         irq_high_group_oe_n_q <= ~(|oob[5:3]);
      end
   end

endmodule

// *** rtl/adcs_window.v ***
`timescale 1ns/1ns
`include "adcs_regs.vh"
module adcs_window (
   // clock and reset
   input  wire                                   mclk,
   input  wire                                   reset_n,
   // stored result
   input  wire                                   wr_valid,
   input  wire [`ADCS_CH_W-1:0]                  wr_ch,
   input  wire [`ADCS_CODE_W-1:0]                wr_code,
   // limits
   input  wire [`ADCS_NUM_WIN*`ADCS_CODE_W-1:0]  upper_flat,
   input  wire [`ADCS_NUM_WIN*`ADCS_CODE_W-1:0]  lower_flat,
   // flags
   output wire [`ADCS_NUM_WIN-1:0]               oob
);

   genvar g;
   generate
      for (g = 0; g < `ADCS_NUM_WIN; g = g + 1) begin : win
         // channels 1-3 sit at 0-2, channels 9-11 at 8-10
         localparam integer CH = (g < 3) ? g : g + 5;
         wire [11:0] up = upper_flat[g*12 +: 12];
         wire [11:0] lo = lower_flat[g*12 +: 12];
         reg         oob_q;
         assign oob[g] = oob_q;
         // R16: always-on window compare
         always @(posedge mclk) begin
            if (!reset_n) begin
               oob_q <= 1'b0;
            end else if (wr_valid && wr_ch == CH[4:0]) begin
               oob_q <= (wr_code > up) || (wr_code < lo);
            end
         end
      end
   endgenerate

endmodule

// *** testbench/adcs_afe_model.sv ***
`timescale 1ns/1ns
module adcs_afe_model #(
   parameter integer VREF_EXT_MV = 3000,
   parameter integer VREF_INT_MV = 2500
) (
   input  wire         mclk,
   input  wire [4:0]   mux_sel_q,
   input  wire         mux_closed_q,
   input  wire [11:0]  trial_q,
   input  wire         ref_internal_en_q,
   input  wire [271:0] vin_mv_flat,
   output reg          comp_hi
);
   integer held_mv = 0;
   integer vref_mv;
   // seventeen inputs, index 16 is temperature
   always @(posedge mclk)
      if (mux_closed_q)
         held_mv <= vin_mv_flat[mux_sel_q*16 +: 16];
   // hold value judged against the trial level
   always @* begin
      vref_mv = ref_internal_en_q ? VREF_INT_MV : VREF_EXT_MV;
      comp_hi = held_mv * 4096 >= trial_q * vref_mv;
   end
endmodule

// *** testbench/adcs_checker_assertions.sv ***
`timescale 1ns/1ns
module adcs_checker #(
   parameter [15:0] TRACK_CYC = 16'd100
) (
   input wire       mclk,
   input wire       reset_n,
   input wire       single_shot_trigger,
   input wire       continuous_run,
   input wire       ref_select_internal,
   input wire       busy_q,
   input wire       any_oob_q,
   input wire [5:0] oob_flags_q,
   input wire       mux_closed_q,
   input wire       ref_internal_en_q,
   input wire       blk_start,
   input wire [7:0] blk_cmd,
   input wire       blk_error_q,
   input wire       blk_active_q,
   input wire       irq_low_group_o_q,
   input wire       irq_low_group_oe_n_q,
   input wire       irq_high_group_o_q,
   input wire       irq_high_group_oe_n_q
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   // counts track cycles; a counter avoids a long repetition
   reg [15:0] trk_q;
   always @(posedge mclk) trk_q <= mux_closed_q ? trk_q + 16'd1 : 16'd0;

   idle_stays_a:
      assert property (!busy_q && !single_shot_trigger && !continuous_run
         |=> !busy_q) else $error("busy without a start");
   start_taken_a:
      assert property (!busy_q && (single_shot_trigger || continuous_run)
         |=> busy_q) else $error("start not taken");
   track_len_a:
      assert property ($fell(mux_closed_q) |-> trk_q == TRACK_CYC)
         else $error("track length wrong");
   hold_open_a:
      assert property ($fell(mux_closed_q) |-> !mux_closed_q [*8])
         else $error("switch closed during hold");
   idle_open_a:
      assert property (!busy_q |-> !mux_closed_q)
         else $error("switch closed while idle");
   irq_groups_a:
      assert property (irq_low_group_oe_n_q == !(|oob_flags_q[2:0])
         && irq_high_group_oe_n_q == !(|oob_flags_q[5:3])
         && !irq_low_group_o_q && !irq_high_group_o_q)
         else $error("interrupt pin mismatch");
   any_oob_a:
      assert property (any_oob_q == (|oob_flags_q))
         else $error("summary flag mismatch");
   ref_follow_a:
      assert property (ref_internal_en_q == $past(ref_select_internal))
         else $error("reference select not followed");
   bad_cmd_a:
      assert property (blk_start && blk_cmd != 8'h40 && blk_cmd != 8'h46
         |=> blk_error_q ##1 !blk_error_q) else $error("bad command missed");
   good_cmd_a:
      assert property (blk_start && (blk_cmd == 8'h40 || blk_cmd == 8'h46)
         |=> blk_active_q && !blk_error_q) else $error("block not opened");
endmodule

bind adcs_sequencer adcs_checker #(.TRACK_CYC(TRACK_CYC)) i_chk (
   .mclk, .reset_n, .single_shot_trigger, .continuous_run,
   .ref_select_internal, .busy_q, .any_oob_q, .oob_flags_q, .mux_closed_q,
   .ref_internal_en_q, .blk_start, .blk_cmd, .blk_error_q, .blk_active_q,
   .irq_low_group_o_q, .irq_low_group_oe_n_q, .irq_high_group_o_q,
   .irq_high_group_oe_n_q
);

// *** testbench/tb_adcs_sequencer.sv ***
`timescale 1ns/1ns
module tb_adcs_sequencer;
   reg          mclk = 1'b0, reset_n = 1'b0;
   reg  [7:0]   channel_enable_reg_a = 8'h00, channel_enable_reg_b = 8'h00;
   reg          channel_enable_reg_c = 1'b0, single_shot_trigger = 1'b0;
   reg          continuous_run = 1'b0, ref_select_internal = 1'b0;
   reg  [4:0]   result_sel = 5'h00;
   reg          blk_start = 1'b0, blk_byte_valid = 1'b0, blk_write = 1'b0;
   reg  [7:0]   blk_cmd = 8'h00, blk_wr_byte = 8'h00;
   reg  [271:0] vin_mv_flat = 272'h0;
   wire         busy_q, seq_done_q, any_oob_q, comp_hi, mux_closed_q;
   wire [5:0]   oob_flags_q;
   wire [4:0]   mux_sel_q;
   wire [11:0]  trial_q, channel_result_reg_q;
   wire [7:0]   blk_rd_byte_q;
   wire         ref_internal_en_q, blk_active_q, blk_error_q;
   wire         irq_low_group_o_q, irq_low_group_oe_n_q;
   wire         irq_high_group_o_q, irq_high_group_oe_n_q;
   integer      miscompares = 0, n_checks = 0, i, n;
   reg  [7:0]   img [0:23];
   reg  [4:0]   order [$];
   reg          mc_d = 1'b0;

   always #10 mclk = ~mclk;

   // short track and bit slots keep the run brief
   adcs_sequencer #(.TRACK_CYC(16'd4), .BIT_CYC(16'd4)) i_dut (
      .mclk, .reset_n, .channel_enable_reg_a, .channel_enable_reg_b,
      .channel_enable_reg_c, .single_shot_trigger, .continuous_run,
      .ref_select_internal, .busy_q, .seq_done_q, .any_oob_q, .oob_flags_q,
      .comp_hi, .mux_sel_q, .mux_closed_q, .trial_q, .ref_internal_en_q,
      .result_sel, .channel_result_reg_q, .blk_start, .blk_cmd,
      .blk_byte_valid, .blk_write, .blk_wr_byte, .blk_rd_byte_q,
      .blk_active_q, .blk_error_q, .irq_low_group_o_q,
      .irq_low_group_oe_n_q, .irq_high_group_o_q, .irq_high_group_oe_n_q);

   adcs_afe_model i_afe (.mclk, .mux_sel_q, .mux_closed_q, .trial_q,
      .ref_internal_en_q, .vin_mv_flat, .comp_hi);

   // channel order seen at the start of each track
   always @(posedge mclk) begin
      if (mux_closed_q && !mc_d)
         order.push_back(mux_sel_q);
      mc_d <= mux_closed_q;
   end

   task cmp(input [15:0] got, input [15:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask

   task stop_test;
      begin
         if (miscompares == 0 && n_checks > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask

   function [11:0] code(input integer mv, input integer vref);
      code = mv * 4096 / vref;
   endfunction

   task single(input [7:0] a, input [7:0] b, input c);
      begin
         @(posedge mclk);
         channel_enable_reg_a <= a;
         channel_enable_reg_b <= b;
         channel_enable_reg_c <= c;
         single_shot_trigger <= 1'b1;
         @(posedge mclk);
         single_shot_trigger <= 1'b0;
      end
   endtask

   task wait_done(input integer lim);
      integer k;
      begin
         k = 0;
         @(posedge mclk);
         #1;
         while (seq_done_q !== 1'b1 && k < lim) begin
            @(posedge mclk);
            #1;
            k = k + 1;
         end
         cmp(seq_done_q, 1);
      end
   endtask

   // bounded wait for the run to go idle
   task wait_idle;
      integer k;
      begin
         k = 0;
         while (busy_q !== 1'b0 && k < 300) begin
            @(posedge mclk);
            #1;
            k = k + 1;
         end
         repeat (3) @(posedge mclk);
         #1;
         cmp(busy_q, 0);
      end
   endtask

   task rd_res(input [4:0] ch, input [11:0] e);
      begin
         @(posedge mclk);
         result_sel <= ch;
         @(posedge mclk);
         #1;
         cmp(channel_result_reg_q, e);
      end
   endtask

   // one byte every second cycle; reads compare against the image
   task blk(input [7:0] cmd, input integer cnt, input wr);
      integer k, base;
      begin
         base = (cmd == 8'h46) ? 12 : 0;
         @(posedge mclk);
         blk_start <= 1'b1;
         blk_cmd <= cmd;
         @(posedge mclk);
         blk_start <= 1'b0;
         for (k = 0; k < cnt; k = k + 1) begin
            blk_byte_valid <= 1'b1;
            blk_write <= wr;
            blk_wr_byte <= img[base+k];
            @(posedge mclk);
            blk_byte_valid <= 1'b0;
            #1;
            if (!wr)
               cmp(blk_rd_byte_q, img[base+k]);
            @(posedge mclk);
         end
         #1;
         cmp(blk_active_q, 0);
      end
   endtask

   initial begin
      vin_mv_flat[0+:16] = 16'd1000;
      vin_mv_flat[16+:16] = 16'd1500;
      vin_mv_flat[32+:16] = 16'd2000;
      vin_mv_flat[128+:16] = 16'd500;
      vin_mv_flat[256+:16] = 16'd700;
      for (i = 0; i < 24; i = i + 1)
         img[i] = (i < 12) ? ((i % 2) ? 8'hff : 8'h0f) : 8'h00;
      repeat (4) @(posedge mclk);
      reset_n <= 1'b1;
      blk(8'h40, 24, 1'b0);
      blk(8'h41, 0, 1'b0);
      cmp(blk_error_q, 1);
      @(posedge mclk);
      channel_enable_reg_a <= 8'h05;
      repeat (30) @(posedge mclk);
      #1;
      cmp(busy_q, 0);
      single(8'h05, 8'h00, 1'b1);
      wait_done(1000);
      wait_idle;
      cmp({order[0], order[1], order[2]}, {5'd0, 5'd2, 5'd16});
      rd_res(5'd0, code(1000, 3000));
      rd_res(5'd1, 12'h000);
      rd_res(5'd2, code(2000, 3000));
      rd_res(5'd16, code(700, 3000));
      cmp(irq_low_group_oe_n_q, 1);
      img[0] = 8'h04;
      img[1] = 8'h00;
      blk(8'h40, 24, 1'b1);
      img[18] = 8'h03;
      blk(8'h46, 12, 1'b1);
      blk(8'h46, 12, 1'b0);
      blk(8'h40, 24, 1'b0);
      single(8'h01, 8'h01, 1'b0);
      wait_done(1000);
      repeat (3) @(posedge mclk);
      #1;
      cmp(irq_low_group_oe_n_q, 0);
      cmp(irq_high_group_oe_n_q, 0);
      cmp(oob_flags_q, 6'h09);
      cmp(any_oob_q, 1);
      @(posedge mclk);
      ref_select_internal <= 1'b1;
      single(8'h02, 8'h00, 1'b0);
      wait_done(1000);
      rd_res(5'd1, code(1500, 2500));
      @(posedge mclk);
      continuous_run <= 1'b1;
      n = 0;
      repeat (300) begin
         @(posedge mclk);
         #1;
         if (seq_done_q === 1'b1)
            n = n + 1;
      end
      cmp(n >= 3, 1);
      @(posedge mclk);
      continuous_run <= 1'b0;
      wait_idle;
      single(8'h00, 8'h00, 1'b0);
      wait_done(4);
      wait_idle;
      @(posedge mclk);
      continuous_run <= 1'b1;
      n = 0;
      repeat (10) begin
         @(posedge mclk);
         #1;
         if (seq_done_q === 1'b1)
            n = n + 1;
      end
      cmp(n >= 4, 1);
      @(posedge mclk);
      continuous_run <= 1'b0;
      wait_idle;
      stop_test;
   end

   // the whole sequence needs well under 20000 cycles
   initial begin
      #400000;
      miscompares = miscompares + 1;
      stop_test;
   end
endmodule
